// file: rtl/hbhc_core.sv
// host bus cycle handler: snoops, special cycles, locks and routing
//
// Behaviour
// - modified hit in snoop phase gives an implicit writeback response
// - write hitting modified line carries two beats: write data then writeback
// - snoopable hub or agp write to dram issues zero-length read-and-invalidate
// - snoopable hub or agp read from dram issues zero-length memory read
// - interrupt acknowledge always goes to the hub link, never agp
// - during host dram lock, hub and agp dram accesses are held off
// - locked sequence to hub sends lock message first, unlock after unless host lock drops while a hub cycle or broadcast message is issued
// - while host lock is active, requests needing a snoop are deferred
// - agp-bound host cycles forwarded the same whether locked or not
// - branch trace retired normally, data discarded, nothing else done
// - special cycle is 01000 / xx001, type from second phase bits 15:8
// - host shutdown, halt and stop-grant-ack special cycles are routed toward the hub link
// - other special cycles are posted, retired without waiting for the hub
// - flush, sync and flush-acknowledge are retired locally, not forwarded
// - shutdown, halt, stop-grant-ack broadcast on hub, retired after success
// - management acknowledge with flag set opens management space
// - management acknowledge with flag clear closes management space
// - no special cycle is ever forwarded to agp
// - posted host writes to hub or agp are write-combined
`timescale 1ns/1ps
`default_nettype none
module hbhc_core (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       host_req_valid,
    input  wire hbhc_pkg::hbhc_host_req_type host_req,
    input  wire logic                       snoop_valid,
    input  wire logic                       snoop_modified_hit,
    input  wire logic                       host_lock_active,
    input  wire logic                       hub_bcast_done,
    input  wire hbhc_pkg::hbhc_io_req_type  io_req,
    output logic                            host_req_ready,
    output logic [2:0]                      resp_code,
    output logic [1:0]                      resp_data_beats,
    output var hbhc_pkg::hbhc_hub_msg_type  hub_msg,
    output logic                            agp_fwd_valid,
    output logic                            agp_fwd_write,
    output logic                            snoop_issue_valid,
    output logic [4:0]                      snoop_issue_code,
    output logic                            io_dram_hold,
    output logic                            io_req_accept,
    output logic                            mgmt_space_open,
    output logic                            write_combine_en
);
    ////////////////////////////////////////////////////////////////////////////
    // request decode
    hbhc_pkg::hbhc_state_type    state_reg;
    hbhc_pkg::hbhc_state_type    state_next;
    hbhc_pkg::hbhc_host_req_type req_reg;
    logic                        lock_hub_reg;
    logic                        lock_prev_reg;
    logic                        mgmt_reg;
    logic                        hit_reg;
    logic                        is_special;
    logic                        is_intack;
    logic                        is_brtrace;
    logic                        is_mem;
    logic                        msg_bcast;
    logic                        cur_hub;
    logic                        need_lock_msg;
    logic                        unlock_now;

    // cycle classification of the latched request
    assign is_special = (req_reg.request_code_first == hbhc_pkg::REQ_SPECIAL_FIRST)
                      && (req_reg.request_code_second[2:0] == hbhc_pkg::REQ_SPECIAL_SECOND);
    assign is_intack  = (req_reg.request_code_first == hbhc_pkg::REQ_SPECIAL_FIRST)
                      && (req_reg.request_code_second[2:0] == hbhc_pkg::REQ_INTACK_SECOND);
    assign is_brtrace = (req_reg.request_code_first == hbhc_pkg::REQ_BRTRACE_FIRST)
                      && (req_reg.request_code_second == hbhc_pkg::REQ_BRTRACE_SECOND);
    assign is_mem     = !is_special && !is_intack && !is_brtrace;
    // messages that must be broadcast before retiring
    assign msg_bcast  = (req_reg.second_phase_type_field == hbhc_pkg::MSG_SHUTDOWN)
                      || (req_reg.second_phase_type_field == hbhc_pkg::MSG_HALT)
                      || (req_reg.second_phase_type_field == hbhc_pkg::MSG_STOP_ACK);
    // management-space accesses stay off the hub
    assign cur_hub    = is_intack
                      || (is_mem && req_reg.dest == hbhc_pkg::HBHC_DST_HUB
                          && !(mgmt_reg && req_reg.mgmt_space_flag));
    assign need_lock_msg = host_req_valid && host_req.locked && !lock_hub_reg
                      && host_req.dest == hbhc_pkg::HBHC_DST_HUB;
    assign unlock_now = lock_prev_reg && !host_lock_active && lock_hub_reg;

    ////////////////////////////////////////////////////////////////////////////
    // state sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            hbhc_pkg::HBHC_IDLE: begin
                if (host_req_valid) begin
                    state_next = need_lock_msg ? hbhc_pkg::HBHC_LOCK : hbhc_pkg::HBHC_SNOOP;
                end
            end
            hbhc_pkg::HBHC_LOCK: begin
                state_next = hbhc_pkg::HBHC_SNOOP;
            end
            hbhc_pkg::HBHC_SNOOP: begin
                if (is_special) begin
                    state_next = msg_bcast ? hbhc_pkg::HBHC_BCAST : hbhc_pkg::HBHC_RESP;
                end else if (!is_mem || snoop_valid) begin
                    state_next = hbhc_pkg::HBHC_RESP;
                end
            end
            hbhc_pkg::HBHC_BCAST: begin
                if (hub_bcast_done) begin
                    state_next = hbhc_pkg::HBHC_RESP;
                end
            end
            hbhc_pkg::HBHC_RESP: begin
                state_next = hbhc_pkg::HBHC_IDLE;
            end
            default: begin
                state_next = hbhc_pkg::HBHC_IDLE;
            end
        endcase
    end

    // state register and request latch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= hbhc_pkg::HBHC_IDLE;
            req_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == hbhc_pkg::HBHC_IDLE && host_req_valid) begin
                req_reg <= host_req;
            end
        end
    end

    // ready only when idle, so one host request is handled at a time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            host_req_ready <= 1'b0;
        end else begin
            host_req_ready <= (state_next == hbhc_pkg::HBHC_IDLE);
        end
    end

    // snoop result capture for the current host cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hit_reg <= 1'b0;
        end else if (state_reg == hbhc_pkg::HBHC_SNOOP && is_mem && snoop_valid) begin
            hit_reg <= snoop_modified_hit;
        end else if (state_reg == hbhc_pkg::HBHC_IDLE) begin
            hit_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // response phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            resp_code       <= hbhc_pkg::RSP_IDLE;
            resp_data_beats <= 2'h0;
        end else if (state_reg == hbhc_pkg::HBHC_RESP) begin
            if (is_mem && hit_reg) begin
                resp_code       <= hbhc_pkg::RSP_IMPLICIT_WB;
                resp_data_beats <= req_reg.write ? hbhc_pkg::WB_WRITE_BEATS
                                                 : hbhc_pkg::ONE_BEAT;
            end else if ((is_mem || is_intack) && !req_reg.write) begin
                resp_code       <= hbhc_pkg::RSP_NORMAL;
                resp_data_beats <= hbhc_pkg::ONE_BEAT;
            end else begin
                resp_code       <= hbhc_pkg::RSP_NO_DATA;
                resp_data_beats <= 2'h0;
            end
        end else begin
            resp_code       <= hbhc_pkg::RSP_IDLE;
            resp_data_beats <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hub link messages: lock, unlock, cycles and broadcast specials
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hub_msg <= '0;
        end else if (state_reg == hbhc_pkg::HBHC_IDLE && need_lock_msg) begin
            hub_msg.valid    <= 1'b1;
            hub_msg.kind     <= hbhc_pkg::HBHC_HUB_LOCK;
            hub_msg.msg_type <= 8'h00;
            hub_msg.write    <= 1'b0;
        end else if (state_reg == hbhc_pkg::HBHC_SNOOP && is_special && msg_bcast) begin
            hub_msg.valid    <= 1'b1;
            hub_msg.kind     <= hbhc_pkg::HBHC_HUB_SPEC;
            hub_msg.msg_type <= req_reg.second_phase_type_field;
            hub_msg.write    <= 1'b0;
        end else if (state_reg == hbhc_pkg::HBHC_RESP && cur_hub) begin
            hub_msg.valid    <= 1'b1;
            hub_msg.kind     <= hbhc_pkg::HBHC_HUB_CYCLE;
            hub_msg.msg_type <= 8'h00;
            hub_msg.write    <= req_reg.write;
        end else if (unlock_now) begin
            hub_msg.valid    <= 1'b1;
            hub_msg.kind     <= hbhc_pkg::HBHC_HUB_UNLOCK;
            hub_msg.msg_type <= 8'h00;
            hub_msg.write    <= 1'b0;
        end else begin
            hub_msg <= '0;
        end
    end

    // hub lock tracking; set wins over the release edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lock_hub_reg  <= 1'b0;
            lock_prev_reg <= 1'b0;
        end else begin
            lock_prev_reg <= host_lock_active;
            if (state_reg == hbhc_pkg::HBHC_IDLE && need_lock_msg) begin
                lock_hub_reg <= 1'b1;
            end else if (unlock_now) begin
                lock_hub_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // agp forwarding: lock attribute ignored, specials never sent
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            agp_fwd_valid <= 1'b0;
            agp_fwd_write <= 1'b0;
        end else begin
            agp_fwd_valid <= state_reg == hbhc_pkg::HBHC_RESP && is_mem
                          && req_reg.dest == hbhc_pkg::HBHC_DST_AGP
                          && !(mgmt_reg && req_reg.mgmt_space_flag);
            agp_fwd_write <= req_reg.write;
        end
    end

    // write combining for posted host writes to hub or agp
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            write_combine_en <= 1'b0;
        end else begin
            write_combine_en <= state_reg == hbhc_pkg::HBHC_RESP && is_mem && req_reg.write
                             && req_reg.dest != hbhc_pkg::HBHC_DST_DRAM;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // management space open and close
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mgmt_reg <= 1'b0;
        end else if (state_reg == hbhc_pkg::HBHC_RESP && is_special
                     && req_reg.second_phase_type_field == hbhc_pkg::MSG_SMI_ACK) begin
            mgmt_reg <= req_reg.mgmt_space_flag;
        end
    end
    assign mgmt_space_open = mgmt_reg;

    ////////////////////////////////////////////////////////////////////////////
    // snoops and hold-off for hub and agp masters
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            snoop_issue_valid <= 1'b0;
            snoop_issue_code  <= 5'h00;
            io_dram_hold      <= 1'b0;
            io_req_accept     <= 1'b0;
        end else begin
            io_dram_hold      <= io_req.valid && io_req.to_dram && host_lock_active;
            io_req_accept     <= io_req.valid && !(host_lock_active
                                 && (io_req.to_dram || io_req.snoopable));
            snoop_issue_valid <= io_req.valid && io_req.to_dram && io_req.snoopable
                              && !host_lock_active;
            snoop_issue_code  <= io_req.write ? hbhc_pkg::SNP_READ_INVAL
                                              : hbhc_pkg::SNP_MEM_READ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_iwb_on_hit: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_RESP && is_mem && hit_reg
        |=> resp_code == hbhc_pkg::RSP_IMPLICIT_WB)
        else $error("modified hit without implicit writeback");
    chk_write_two_beats: assert property (@(posedge core_clk) disable iff (!rst_n)
        resp_code == hbhc_pkg::RSP_IMPLICIT_WB && $past(req_reg.write)
        |-> resp_data_beats == hbhc_pkg::WB_WRITE_BEATS)
        else $error("write hit lacks two data beats");
    chk_snoop_code_kind: assert property (@(posedge core_clk) disable iff (!rst_n)
        io_req.valid && io_req.to_dram && io_req.snoopable && !host_lock_active
        |=> snoop_issue_valid && snoop_issue_code == ($past(io_req.write)
            ? hbhc_pkg::SNP_READ_INVAL : hbhc_pkg::SNP_MEM_READ))
        else $error("wrong snoop code for master access");
    chk_no_snoop_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_lock_active |=> !snoop_issue_valid)
        else $error("snoop issued during host lock");
    chk_dram_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        io_req.valid && io_req.to_dram && host_lock_active |=> io_dram_hold && !io_req_accept)
        else $error("dram access not held during lock");
    chk_lock_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_IDLE && need_lock_msg
        |=> hub_msg.valid && hub_msg.kind == hbhc_pkg::HBHC_HUB_LOCK)
        else $error("lock message missing before locked read");
    chk_bcast_before_retire: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_BCAST && !hub_bcast_done |=> state_reg != hbhc_pkg::HBHC_RESP)
        else $error("broadcast message retired early");
    chk_local_msg_posted: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_SNOOP && is_special && !msg_bcast
        |=> ##1 resp_code == hbhc_pkg::RSP_NO_DATA && !hub_msg.valid)
        else $error("local special not retired at once");
    chk_no_agp_special: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(state_reg) == hbhc_pkg::HBHC_RESP && $past(!is_mem) |-> !agp_fwd_valid)
        else $error("special cycle forwarded to agp");
    chk_mgmt_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_RESP && is_special
        && req_reg.second_phase_type_field == hbhc_pkg::MSG_SMI_ACK
        |=> mgmt_space_open == $past(req_reg.mgmt_space_flag))
        else $error("management space state not updated");
    cov_write_hit: cover property (@(posedge core_clk) disable iff (!rst_n)
        resp_code == hbhc_pkg::RSP_IMPLICIT_WB && resp_data_beats == hbhc_pkg::WB_WRITE_BEATS);
    cov_bcast_special: cover property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == hbhc_pkg::HBHC_BCAST ##[1:8] state_reg == hbhc_pkg::HBHC_RESP);
    cov_lock_unlock: cover property (@(posedge core_clk) disable iff (!rst_n)
        hub_msg.valid && hub_msg.kind == hbhc_pkg::HBHC_HUB_UNLOCK);
    cov_mgmt_open: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(mgmt_space_open));
endmodule : hbhc_core
`default_nettype wire

// file: inc/hbhc_pkg.sv
// package: encodings, states and carriers of the host bus cycle handler
package hbhc_pkg;
    // request codes of the first and second request phases
    localparam logic [4:0] REQ_SPECIAL_FIRST   = 5'h08;  // 01000
    localparam logic [2:0] REQ_SPECIAL_SECOND  = 3'h1;   // xx001, low three bits
    localparam logic [2:0] REQ_INTACK_SECOND   = 3'h0;   // xx000, low three bits
    localparam logic [4:0] REQ_BRTRACE_FIRST   = 5'h09;  // 01001
    localparam logic [4:0] REQ_BRTRACE_SECOND  = 5'h00;
    // special message type codes
    localparam logic [7:0] MSG_NOP        = 8'h00;
    localparam logic [7:0] MSG_SHUTDOWN   = 8'h01;
    localparam logic [7:0] MSG_FLUSH      = 8'h02;
    localparam logic [7:0] MSG_HALT       = 8'h03;
    localparam logic [7:0] MSG_SYNC       = 8'h04;
    localparam logic [7:0] MSG_FLUSH_ACK  = 8'h05;
    localparam logic [7:0] MSG_STOP_ACK   = 8'h06;
    localparam logic [7:0] MSG_SMI_ACK    = 8'h07;
    // response codes on the host bus
    localparam logic [2:0] RSP_IDLE       = 3'h0;
    localparam logic [2:0] RSP_NO_DATA    = 3'h5;
    localparam logic [2:0] RSP_IMPLICIT_WB = 3'h6;
    localparam logic [2:0] RSP_NORMAL     = 3'h7;
    // snoop request codes issued for hub and agp masters
    localparam logic [4:0] SNP_READ_INVAL = 5'h02;  // zero_length_read_invalidate
    localparam logic [4:0] SNP_MEM_READ   = 5'h06;  // zero_length_snoop_read
    // data beats of a write that hits a modified line and of a read with data
    localparam logic [1:0] WB_WRITE_BEATS = 2'h2;
    localparam logic [1:0] ONE_BEAT       = 2'h1;
    // destinations of a host transaction
    typedef enum logic [1:0] {
        HBHC_DST_DRAM = 2'b00,
        HBHC_DST_HUB  = 2'b01,
        HBHC_DST_AGP  = 2'b10
    } hbhc_dest_type;
    // kinds of message sent toward the hub link
    typedef enum logic [1:0] {
        HBHC_HUB_CYCLE  = 2'b00,
        HBHC_HUB_LOCK   = 2'b01,
        HBHC_HUB_UNLOCK = 2'b10,
        HBHC_HUB_SPEC   = 2'b11
    } hbhc_hub_kind_type;
    // handler states
    typedef enum logic [2:0] {
        HBHC_IDLE  = 3'b000,
        HBHC_LOCK  = 3'b001,
        HBHC_SNOOP = 3'b010,
        HBHC_BCAST = 3'b011,
        HBHC_RESP  = 3'b100
    } hbhc_state_type;
    // host request as decoded from the two request phases
    typedef struct packed {
        logic [4:0]    request_code_first;
        logic [4:0]    request_code_second;
        logic [7:0]    second_phase_type_field;
        logic          mgmt_space_flag;
        logic          write;
        logic          locked;
        hbhc_dest_type dest;
    } hbhc_host_req_type;
    // message toward the hub link
    typedef struct packed {
        logic              valid;
        hbhc_hub_kind_type kind;
        logic [7:0]        msg_type;
        logic              write;
    } hbhc_hub_msg_type;
    // access request from a hub or agp frame-protocol master
    typedef struct packed {
        logic valid;
        logic write;
        logic to_dram;
        logic snoopable;
    } hbhc_io_req_type;
endpackage : hbhc_pkg

// file: bench/hbhc_cpu_model.sv
// processor model on the host bus: answers the snoop phase of each taken request
`timescale 1ns/1ps
`default_nettype none
module hbhc_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       host_req_valid,
    input  wire logic       host_req_ready,
    input  wire logic       hit_cfg,
    input  wire logic [3:0] delay_cfg,
    output logic            snoop_valid,
    output logic            snoop_modified_hit
);
    logic [3:0] count_reg;
    ////////////////////////////////////////////////////////////////////////////
    // snoop result comes delay_cfg cycles after a taken request
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_reg          <= 4'h0;
            snoop_valid        <= 1'h0;
            snoop_modified_hit <= 1'h0;
        end else begin
            if (host_req_valid && host_req_ready) begin
                count_reg <= delay_cfg;
            end else if (count_reg != 4'h0) begin
                count_reg <= count_reg - 4'h1;
            end
            snoop_valid <= (count_reg == 4'h1);
            // hit line only meaningful in the snoop phase, toggles otherwise
            snoop_modified_hit <= (count_reg == 4'h1) ? hit_cfg : ~snoop_modified_hit;
        end
    end
endmodule : hbhc_cpu_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench of the host bus cycle handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {
        logic [4:0] f;
        logic w, lk;
        logic [1:0] d;
        logic hit;
        logic [2:0] rsp;
        logic [1:0] bt, hb, ag, wc;
    } hbhc_row_type;
    hbhc_row_type rows[9] = '{
        '{5'h06, 1'h0, 1'h0, 2'h0, 1'h0, 3'h7, 2'h1, 2'h0, 2'h0, 2'h0},
        '{5'h06, 1'h0, 1'h0, 2'h0, 1'h1, 3'h6, 2'h1, 2'h0, 2'h0, 2'h0},
        '{5'h07, 1'h1, 1'h0, 2'h0, 1'h1, 3'h6, 2'h2, 2'h0, 2'h0, 2'h0},
        '{5'h07, 1'h1, 1'h0, 2'h0, 1'h0, 3'h5, 2'h0, 2'h0, 2'h0, 2'h0},
        '{5'h08, 1'h0, 1'h0, 2'h2, 1'h0, 3'h0, 2'h0, 2'h1, 2'h0, 2'h0},
        '{5'h09, 1'h1, 1'h0, 2'h1, 1'h0, 3'h0, 2'h0, 2'h0, 2'h0, 2'h0},
        '{5'h07, 1'h1, 1'h0, 2'h2, 1'h0, 3'h0, 2'h0, 2'h0, 2'h1, 2'h1},
        '{5'h07, 1'h1, 1'h1, 2'h2, 1'h0, 3'h0, 2'h0, 2'h0, 2'h1, 2'h1},
        '{5'h07, 1'h1, 1'h0, 2'h1, 1'h0, 3'h0, 2'h0, 2'h1, 2'h0, 2'h1}};
    logic [7:0] codes[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'hA5};
    logic core_clk = 1'h0, rst_n = 1'h0, host_req_valid = 1'h0, hit_cfg = 1'h0;
    logic host_lock_active = 1'h0, hub_bcast_done = 1'h0, snoop_valid, snoop_modified_hit;
    logic [3:0] delay_cfg = 4'h1;
    hbhc_pkg::hbhc_host_req_type host_req = '0;
    hbhc_pkg::hbhc_io_req_type   io_req = '0;
    hbhc_pkg::hbhc_hub_msg_type  hub_msg;
    logic host_req_ready, agp_fwd_valid, agp_fwd_write, snoop_issue_valid, io_dram_hold;
    logic io_req_accept, mgmt_space_open, write_combine_en, early, bc, aw, hw;
    logic [2:0] resp_code, rs;
    logic [1:0] resp_data_beats, bt, k0, k1;
    logic [4:0] snoop_issue_code;
    logic [7:0] hub_n, agp_n, wc_n, hub_t;
    int fail_count = 0, compares = 0, cyc = 0;
    hbhc_core u_dut (.core_clk(core_clk), .rst_n(rst_n), .host_req_valid(host_req_valid), .host_req(host_req),
        .snoop_valid(snoop_valid), .snoop_modified_hit(snoop_modified_hit), .host_lock_active(host_lock_active),
        .hub_bcast_done(hub_bcast_done), .io_req(io_req), .host_req_ready(host_req_ready), .resp_code(resp_code),
        .resp_data_beats(resp_data_beats), .hub_msg(hub_msg), .agp_fwd_valid(agp_fwd_valid),
        .agp_fwd_write(agp_fwd_write), .snoop_issue_valid(snoop_issue_valid), .snoop_issue_code(snoop_issue_code),
        .io_dram_hold(io_dram_hold), .io_req_accept(io_req_accept), .mgmt_space_open(mgmt_space_open),
        .write_combine_en(write_combine_en));
    hbhc_cpu_model u_cpu (.core_clk(core_clk), .rst_n(rst_n), .host_req_valid(host_req_valid),
        .host_req_ready(host_req_ready), .hit_cfg(hit_cfg), .delay_cfg(delay_cfg), .snoop_valid(snoop_valid),
        .snoop_modified_hit(snoop_modified_hit));
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang limit
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one host request, logging hub, agp and combine pulses until the response
    task automatic run(input hbhc_pkg::hbhc_host_req_type rq, input logic hit, input logic bcast);
        int pulse;
        pulse = 0;
        {hub_n, agp_n, wc_n, rs, bt, early, aw, hw} = '0;
        host_req = rq;
        hit_cfg = hit;
        host_req_valid = 1'h1;
        @(posedge core_clk) #2;
        host_req_valid = 1'h0;
        for (int i = 0; i < 60 && rs == 3'h0; i++) begin
            if (hub_msg.valid === 1'h1) begin
                if (hub_n == 8'h0) k0 = hub_msg.kind;
                k1 = hub_msg.kind;
                hw = hub_msg.write;
                hub_t = hub_msg.msg_type;
                hub_n++;
            end
            if (agp_fwd_valid === 1'h1) begin
                agp_n++;
                aw = agp_fwd_write;
            end
            if (write_combine_en === 1'h1) wc_n++;
            if (bcast && hub_n != 8'h0) pulse++;
            hub_bcast_done = (pulse == 3);
            if (resp_code !== 3'h0) begin
                rs = resp_code;
                bt = resp_data_beats;
                early = bcast && pulse <= 3;
            end
            @(posedge core_clk) #2;
        end
        hub_bcast_done = 1'h0;
    endtask : run
    task automatic spec(input logic [7:0] c, input logic fl);
        bc = (c == 8'h01 || c == 8'h03 || c == 8'h06);
        run('{5'h08, 5'h19, c, fl, 1'h0, 1'h0, hbhc_pkg::HBHC_DST_AGP}, 1'h0, bc);
    endtask : spec
    task automatic io(input logic [3:0] r, input logic v, input logic [4:0] cd, input logic acc, input logic hd);
        io_req = r;
        @(posedge core_clk) #2;
        check("snoop issue", 8'(snoop_issue_valid), 8'(v));
        if (v) check("snoop code", 8'(snoop_issue_code), 8'(cd));
        check("io accept", 8'(io_req_accept), 8'(acc));
        check("io hold", 8'(io_dram_hold), 8'(hd));
    endtask : io
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        #2;
        check("reset resp", 8'(resp_code), 8'h00);
        rst_n = 1'h1;
        @(posedge core_clk) #2;
        check("ready", 8'(host_req_ready), 8'h01);
        foreach (rows[i]) begin
            delay_cfg = (i % 2) ? 4'h9 : 4'h1;
            run('{rows[i].f, 5'h00, 8'h00, 1'h0, rows[i].w, rows[i].lk, hbhc_pkg::hbhc_dest_type'(rows[i].d)},
                rows[i].hit, 1'h0);
            if (rows[i].rsp != 3'h0) begin
                check("resp", 8'(rs), 8'(rows[i].rsp));
                check("beats", 8'(bt), 8'(rows[i].bt));
            end else check("retired", 8'(rs != 3'h0), 8'h01);
            check("hub count", hub_n, 8'(rows[i].hb));
            check("agp count", agp_n, 8'(rows[i].ag));
            check("combine", wc_n, 8'(rows[i].wc));
            if (rows[i].ag != 2'h0) check("agp write", 8'(aw), 8'(rows[i].w));
            if (rows[i].hb != 2'h0) check("hub write", 8'(hw), 8'(rows[i].w));
        end
        foreach (codes[i]) begin
            spec(codes[i], 1'h0);
            check("spec resp", 8'(rs), 8'h05);
            check("spec hub", hub_n, bc ? 8'h01 : 8'h00);
            if (bc) check("spec type", hub_t, codes[i]);
            if (bc) check("spec kind", 8'(k1), 8'(hbhc_pkg::HBHC_HUB_SPEC));
            check("spec early", 8'(early), 8'h00);
            check("spec agp", agp_n, 8'h00);
        end
        spec(8'h07, 1'h1);
        check("mgmt open", 8'(mgmt_space_open), 8'h01);
        run('{5'h06, 5'h00, 8'h00, 1'h1, 1'h0, 1'h0, hbhc_pkg::HBHC_DST_HUB}, 1'h0, 1'h0);
        check("mgmt hub", hub_n, 8'h00);
        spec(8'h07, 1'h0);
        check("mgmt closed", 8'(mgmt_space_open), 8'h00);
        // io masters ask for dram access first outside and then during host lock, then a snoopable non-dram access during the lock
        io(4'hF, 1'h1, 5'h02, 1'h1, 1'h0);
        io(4'hB, 1'h1, 5'h06, 1'h1, 1'h0);
        io(4'hE, 1'h0, 5'h00, 1'h1, 1'h0);
        host_lock_active = 1'h1;
        io(4'hF, 1'h0, 5'h00, 1'h0, 1'h1);
        io(4'h9, 1'h0, 5'h00, 1'h0, 1'h0);
        io_req = '0;
        run('{5'h06, 5'h00, 8'h00, 1'h0, 1'h0, 1'h1, hbhc_pkg::HBHC_DST_HUB}, 1'h0, 1'h0);
        check("lock first", 8'(k0), 8'(hbhc_pkg::HBHC_HUB_LOCK));
        check("lock then", 8'(k1), 8'(hbhc_pkg::HBHC_HUB_CYCLE));
        host_lock_active = 1'h0;
        k1 = 2'h0;
        repeat (5) begin
            @(posedge core_clk) #2;
            if (hub_msg.valid === 1'h1) k1 = hub_msg.kind;
        end
        check("unlock", 8'(k1), 8'(hbhc_pkg::HBHC_HUB_UNLOCK));
        spec(8'h07, 1'h1);
        rst_n = 1'h0;
        repeat (2) @(posedge core_clk);
        #2;
        check("reset mgmt", 8'(mgmt_space_open), 8'h00);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
